// [src/uabl_top.sv]
// Serial channel top: register slave, transmitter, receiver, error-tagged receive FIFO
// Behaviour
// - Receive error interrupt waits until the faulty character is next to be read.
// - One error interrupt per faulty character, none for the first character after an error register read of the empty FIFO; clean characters raise none.
// - One baud generator clocks both transmitter and receiver.
// - Baud source is peripheral clock, divided core clock or external clock.
// - Bit rate is source divided by sixteen times divisor plus one.
// - Loopback routes the transmit line into the receiver internally.
// - Infrared transmit sends a 3/16 bit pulse for each zero bit.
// - Infrared receive detects a short pulse within a bit as zero.
// - Line control bit 6 selects normal or infrared signalling.
// - Line control bits 5..3 select none, odd, even, forced one, forced zero parity.
// - Line control bit 2 selects one or two stop bits.
// - Line control bits 1..0 at 00 select five data bits.
// - Frame is start, five to eight data, optional parity, one or two stops.
`timescale 1ns/100ps
`default_nettype none
module uabl_top
	import uabl_pkg::*;
#(
	parameter logic [31:0] BASE_ADDR = UABL_CH0_BASE,
	parameter int          DEPTH     = 64
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Avalon-MM slave
	input  wire logic [31:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Baud sources
	input  wire logic        divided_core_clock_i,
	input  wire logic        external_baud_source_i,
	// Serial line
	input  wire logic        rxd_i,
	output logic             txd_o,
	// Receive error interrupt
	output logic             rx_error_int_o
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	// ********************************************
	// Register bus slave
	// ********************************************
	logic [7:0]  line_control_reg_q;
	logic [15:0] channel_control_reg_q;
	logic [15:0] baud_divisor_reg_q;
	logic [7:0]  hold_q;
	logic        hold_full_q;
	logic [31:0] rd_d;
	logic        hit;
	logic [11:0] ofs;
	logic        wr_en;
	logic        rd_en;
	logic        tx_take;

	assign hit   = (avs_address_i[31:OFS_W] == BASE_ADDR[31:OFS_W]);
	assign ofs   = avs_address_i[OFS_W-1:0];
	// Effects happen only at the edge where the master sees waitrequest low
	assign wr_en = avs_write_i && !avs_waitrequest_o && hit;
	assign rd_en = avs_read_i && !avs_waitrequest_o && hit;

	// Waitrequest drops for exactly one cycle, one cycle after a request appears
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
		end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
			avs_readdata_o    <= avs_read_i ? rd_d : 32'h0000_0000;
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	// Control registers; bit 7 of line control never stores
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			line_control_reg_q    <= LC_RST;
			channel_control_reg_q <= CC_RST;
			baud_divisor_reg_q    <= DIV_RST;
		end else if (wr_en) begin
			case (ofs)
				OFS_LINE: begin
					if (avs_byteenable_i[0]) begin
						line_control_reg_q <= avs_writedata_i[7:0] & LC_MASK;
					end
				end
				OFS_CTRL: channel_control_reg_q <= uabl_be16(channel_control_reg_q,
					avs_writedata_i[15:0], avs_byteenable_i[1:0]);
				OFS_DIV:  baud_divisor_reg_q <= uabl_be16(baud_divisor_reg_q,
					avs_writedata_i[15:0], avs_byteenable_i[1:0]);
				default: ;
			endcase
		end
	end

	// Transmit holding byte; a write while it is full is dropped
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			hold_q      <= 8'h00;
			hold_full_q <= 1'b0;
		end else if (wr_en && ofs == OFS_TXH && avs_byteenable_i[0] && !hold_full_q) begin
			hold_q      <= avs_writedata_i[7:0];
			hold_full_q <= 1'b1;
		end else if (tx_take) begin
			hold_full_q <= 1'b0;
		end
	end

	// Decoded settings
	logic       ir;
	logic       two_stop;
	logic [2:0] par_mode;
	logic [1:0] wl;
	logic [2:0] nlast;
	logic       par_en;
	logic       loop;
	logic       errie;

	assign ir       = line_control_reg_q[LC_IR_BIT];
	assign two_stop = line_control_reg_q[LC_STOP_BIT];
	assign par_mode = line_control_reg_q[5:3];
	assign par_en   = par_mode[2];
	assign wl       = line_control_reg_q[1:0];
	assign nlast    = {1'b1, wl};
	assign loop     = channel_control_reg_q[CC_LOOP_BIT];
	assign errie    = channel_control_reg_q[CC_ERRIE_BIT];

	// ********************************************
	// Baud generator shared by both directions
	// ********************************************
	logic tick16;

	uabl_baud u_baud (
		.clk_i      (clk_i),
		.resetn_i   (resetn_i),
		.clk_sel_i  (channel_control_reg_q[11:10]),
		.divisor_i  (baud_divisor_reg_q),
		.core_div_i (divided_core_clock_i),
		.ext_i      (external_baud_source_i),
		.tick16_o   (tick16)
	);

	// ********************************************
	// Transmitter
	// ********************************************
	uabl_tx_st_t tx_st_q;
	logic [3:0]  tsub_q;
	logic [2:0]  tbit_q;
	logic [7:0]  tsh_q;
	logic        tpar_q;
	logic        tx_line_q;
	logic        tbit_v;
	logic        tlast;

	assign tx_take = tick16 && tx_st_q == TX_IDLE && hold_full_q;
	assign tlast   = (tsub_q == LAST_TICK);

	// Frame sequencer, one bit per sixteen ticks
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tx_st_q <= TX_IDLE;
			tsub_q  <= 4'h0;
			tbit_q  <= 3'h0;
			tsh_q   <= 8'h00;
			tpar_q  <= 1'b0;
		end else if (tick16) begin
			tsub_q <= tsub_q + 4'h1;
			case (tx_st_q)
				TX_IDLE: begin
					tsub_q <= 4'h0;
					if (hold_full_q) begin
						tx_st_q <= TX_START;
						tsh_q   <= hold_q;
						tpar_q  <= uabl_parity(hold_q, wl, par_mode);
					end
				end
				TX_START: begin
					if (tlast) begin
						tx_st_q <= TX_DATA;
						tbit_q  <= 3'h0;
					end
				end
				TX_DATA: begin
					if (tlast) begin
						tsh_q  <= {1'b0, tsh_q[7:1]};
						tbit_q <= tbit_q + 3'h1;
						if (tbit_q == nlast) begin
							tx_st_q <= par_en ? TX_PAR : TX_STOP;
							tbit_q  <= 3'h0;
						end
					end
				end
				TX_PAR: begin
					if (tlast) begin
						tx_st_q <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tlast) begin
						if (two_stop && tbit_q == 3'h0) begin
							tbit_q <= 3'h1;
						end else begin
							tx_st_q <= TX_IDLE;
						end
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// Logical bit value of the current slot
	always_comb begin
		case (tx_st_q)
			TX_START: tbit_v = 1'b0;
			TX_DATA:  tbit_v = tsh_q[0];
			TX_PAR:   tbit_v = tpar_q;
			default:  tbit_v = 1'b1;
		endcase
	end

	// Line encoding: NRZ, or a short pulse for each zero in infrared mode
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tx_line_q <= 1'b1;
			txd_o     <= 1'b1;
		end else begin
			tx_line_q <= ir ? (!tbit_v && tsub_q < IR_PULSE) : tbit_v;
			txd_o     <= loop ? 1'b1 : tx_line_q;
		end
	end

	// ********************************************
	// Receiver
	// ********************************************
	logic [2:0]  rsync_q;
	logic        rx_lvl_q;
	logic        rx_in;
	logic        act;
	logic        rx_v;
	logic        rlast;
	uabl_rx_st_t rx_st_q;
	logic [3:0]  rsub_q;
	logic [2:0]  rbit_q;
	logic [7:0]  rsh_q;
	logic        seen_q;
	logic        samp_q;
	logic        rpar_q;
	logic        rx_push;
	logic [7:0]  rx_data;
	logic [3:0]  rx_err;
	logic        samp_err_q;

	// Pin synchroniser; noise shorter than one clock is filtered
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rsync_q  <= 3'h7;
			rx_lvl_q <= 1'b1;
		end else begin
			rsync_q <= {rsync_q[1:0], rxd_i};
			if (rsync_q[1] == rsync_q[2]) begin
				rx_lvl_q <= rsync_q[2];
			end
		end
	end

	assign rx_in   = loop ? tx_line_q : rx_lvl_q;
	assign act     = ir ? rx_in : !rx_in;
	assign rlast   = (rsub_q == LAST_TICK);
	// Infrared: any pulse in the bit window means zero; NRZ: mid-bit sample
	assign rx_v    = ir ? !(seen_q || act) : samp_q;
	assign rx_data = rsh_q >> (WL_EIGHT - wl);
	assign rx_push = tick16 && rx_st_q == RX_STOP && rlast && !(two_stop && rbit_q == 3'h0);
	assign rx_err  = {!rx_v && rx_data == 8'h00, !rx_v || samp_err_q, rpar_q, 1'b0};

	// Frame receiver, aligned to the detected start edge
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rx_st_q    <= RX_IDLE;
			rsub_q     <= 4'h0;
			rbit_q     <= 3'h0;
			rsh_q      <= 8'h00;
			seen_q     <= 1'b0;
			samp_q     <= 1'b1;
			rpar_q     <= 1'b0;
			samp_err_q <= 1'b0;
		end else if (tick16) begin
			rsub_q <= rsub_q + 4'h1;
			seen_q <= rlast ? 1'b0 : (seen_q || act);
			if (rsub_q == MID_TICK) begin
				samp_q <= rx_in;
			end
			case (rx_st_q)
				RX_IDLE: begin
					rsub_q <= 4'h1;
					seen_q <= act;
					if (act) begin
						rx_st_q    <= RX_START;
						rpar_q     <= 1'b0;
						samp_err_q <= 1'b0;
					end
				end
				RX_START: begin
					if (rlast) begin
						rx_st_q <= rx_v ? RX_IDLE : RX_DATA;
						rbit_q  <= 3'h0;
					end
				end
				RX_DATA: begin
					if (rlast) begin
						rsh_q  <= {rx_v, rsh_q[7:1]};
						rbit_q <= rbit_q + 3'h1;
						if (rbit_q == nlast) begin
							rx_st_q <= par_en ? RX_PAR : RX_STOP;
							rbit_q  <= 3'h0;
						end
					end
				end
				RX_PAR: begin
					if (rlast) begin
						rpar_q  <= (rx_v != uabl_parity(rx_data, wl, par_mode));
						rx_st_q <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rlast) begin
						samp_err_q <= samp_err_q || !rx_v;
						if (two_stop && rbit_q == 3'h0) begin
							rbit_q <= 3'h1;
						end else begin
							rx_st_q <= RX_IDLE;
						end
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// ********************************************
	// Receive FIFO with error tag per character
	// ********************************************
	logic [7:0]  dat_mem [DEPTH];
	logic [3:0]  err_mem [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0]   cnt_q;
	logic        pop;
	logic        push_ok;
	logic [3:0]  head_err;
	logic        err_read_q;

	assign pop      = rd_en && ofs == OFS_RXH && cnt_q != '0;
	assign push_ok  = rx_push && cnt_q != FULL;
	assign head_err = (cnt_q != '0) ? err_mem[rptr_q] : 4'h0;

	// A character that finds the FIFO full is lost and tags the newest entry
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
		end else begin
			if (push_ok) begin
				dat_mem[wptr_q] <= rx_data;
				err_mem[wptr_q] <= rx_err;
				wptr_q          <= wptr_q + 1'b1;
			end else if (rx_push) begin
				err_mem[wptr_q - 1'b1][ERR_OVR] <= 1'b1;
			end
			if (pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW + 1)'(push_ok) - (AW + 1)'(pop);
		end
	end

	// Error entry is acknowledged by reading the error register, freed by the character read
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			err_read_q <= 1'b0;
		end else if (pop) begin
			err_read_q <= 1'b0;
		end else if (rd_en && ofs == OFS_ERR) begin
			err_read_q <= 1'b1;
		end
	end

	// Error interrupt only for the character at the read side
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rx_error_int_o <= 1'b0;
		end else begin
			rx_error_int_o <= errie && head_err != 4'h0 && !err_read_q;
		end
	end

	// Read data multiplexer
	always_comb begin
		rd_d = 32'h0000_0000;
		if (hit) begin
			case (ofs)
				OFS_LINE: rd_d = {24'h000000, line_control_reg_q};
				OFS_CTRL: rd_d = {16'h0000, channel_control_reg_q};
				OFS_DIV:  rd_d = {16'h0000, baud_divisor_reg_q};
				OFS_ERR:  rd_d = {28'h0000000, head_err};
				OFS_RXH:  rd_d = {24'h000000, dat_mem[rptr_q]};
				OFS_STAT: begin
					rd_d[ST_RXRDY] = (cnt_q != '0);
					rd_d[ST_TXHE]  = !hold_full_q;
					rd_d[ST_TXE]   = (tx_st_q == TX_IDLE) && !hold_full_q;
				end
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	// ********************************************
	// Checks
	// ********************************************
	logic [16:0] gap_q;
	logic        gap_arm_q;

	// Cycles since the last baud tick, armed only while settings stay untouched
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			gap_q     <= 17'h00000;
			gap_arm_q <= 1'b0;
		end else begin
			gap_q     <= tick16 ? 17'h00000 : gap_q + 17'h00001;
			gap_arm_q <= wr_en ? 1'b0 : (tick16 || gap_arm_q);
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_ans;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence

	AST_BUS_ANSWER: assert property (s_req |=> s_ans)
		else $error("bus request not answered in one cycle");
	AST_ERR_AT_HEAD: assert property ($rose(rx_error_int_o) |-> $past(head_err) != 4'h0)
		else $error("error interrupt raised for a clean head character");
	AST_ERR_CLEAN: assert property (head_err == 4'h0 |=> !rx_error_int_o)
		else $error("error interrupt without a faulty head character");
	AST_BAUD_DIV: assert property (tick16 && gap_arm_q && $past(gap_arm_q) && !wr_en
		&& channel_control_reg_q[10] == 1'b0 |-> gap_q == {1'b0, baud_divisor_reg_q})
		else $error("baud tick spacing differs from divisor plus one");
	AST_LOOP_IDLE: assert property (loop && $past(loop) |-> txd_o)
		else $error("serial output not idle during loopback");
	// Start bit in infrared mode: high for the first ticks of the slot, low after
	sequence s_ir_head;
		ir && tx_st_q == TX_START && tsub_q < IR_PULSE;
	endsequence
	sequence s_ir_tail;
		ir && tx_st_q == TX_START && tsub_q >= IR_PULSE;
	endsequence

	AST_IR_PULSE: assert property (s_ir_head |=> tx_line_q)
		else $error("infrared zero pulse missing at bit start");
	AST_IR_GAP: assert property (s_ir_tail |=> !tx_line_q)
		else $error("infrared zero pulse longer than its width");
	AST_NRZ_START: assert property (!ir && tx_st_q == TX_START |=> !tx_line_q)
		else $error("start bit not low in normal mode");
	AST_STOP_HIGH: assert property (!ir && tx_st_q == TX_STOP |=> tx_line_q)
		else $error("stop bit not high in normal mode");
	AST_PAR_ONE: assert property (!ir && tx_st_q == TX_PAR && par_mode == PAR_ONE
		&& $stable(par_mode) |=> tx_line_q)
		else $error("forced one parity not sent as one");
	AST_WLEN: assert property (tick16 && tlast && tx_st_q == TX_DATA && tbit_q == nlast
		|=> tx_st_q == TX_PAR || tx_st_q == TX_STOP)
		else $error("data phase length does not match word length");

endmodule
`default_nettype wire

// [src/uabl_pkg.sv]
// Constants, types and shared functions of the serial channel with IR and loopback
package uabl_pkg;

	// ********************************************
	// Register map (byte addresses, one word each)
	// ********************************************
	localparam logic [31:0] UABL_CH0_BASE = 32'h5000_0000;
	localparam logic [31:0] UABL_CH1_BASE = 32'h5000_4000;
	localparam logic [31:0] UABL_CH2_BASE = 32'h5000_8000;
	localparam int          OFS_W         = 12;
	localparam logic [11:0] OFS_LINE      = 12'h000;
	localparam logic [11:0] OFS_CTRL      = 12'h004;
	localparam logic [11:0] OFS_STAT      = 12'h010;
	localparam logic [11:0] OFS_ERR       = 12'h014;
	localparam logic [11:0] OFS_TXH       = 12'h020;
	localparam logic [11:0] OFS_RXH       = 12'h024;
	localparam logic [11:0] OFS_DIV       = 12'h028;

	// ********************************************
	// Fields and reset values
	// ********************************************
	localparam logic [7:0]  LC_RST        = 8'h00;
	localparam logic [7:0]  LC_MASK       = 8'h7F;
	localparam int          LC_IR_BIT     = 6;
	localparam int          LC_STOP_BIT   = 2;
	localparam logic [15:0] CC_RST        = 16'h0000;
	localparam logic [15:0] DIV_RST       = 16'h0000;
	localparam int          CC_ERRIE_BIT  = 6;
	localparam int          CC_LOOP_BIT   = 5;
	localparam logic [1:0]  CLK_SEL_EXT   = 2'h1;
	localparam logic [1:0]  CLK_SEL_CORE  = 2'h3;
	localparam logic [2:0]  PAR_ODD       = 3'h4;
	localparam logic [2:0]  PAR_EVEN      = 3'h5;
	localparam logic [2:0]  PAR_ONE       = 3'h6;
	localparam int          ERR_OVR       = 0;
	localparam int          ERR_PAR       = 1;
	localparam int          ERR_FRM       = 2;
	localparam int          ERR_BRK       = 3;
	localparam int          ST_RXRDY      = 0;
	localparam int          ST_TXHE       = 1;
	localparam int          ST_TXE        = 2;

	// ********************************************
	// Bit timing in 16x oversampling ticks
	// ********************************************
	localparam logic [3:0]  LAST_TICK     = 4'hF;
	localparam logic [3:0]  MID_TICK      = 4'h7;
	localparam logic [3:0]  IR_PULSE      = 4'h3;
	localparam logic [1:0]  WL_EIGHT      = 2'h3;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uabl_tx_st_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uabl_rx_st_t;

	// Parity bit for the active data bits of a character
	function automatic logic uabl_parity(input logic [7:0] d, input logic [1:0] wl,
		input logic [2:0] pm);
		logic [7:0] m;
		m = d & (8'hFF >> (WL_EIGHT - wl));
		case (pm)
			PAR_ODD:  uabl_parity = ~^m;
			PAR_EVEN: uabl_parity = ^m;
			PAR_ONE:  uabl_parity = 1'b1;
			default:  uabl_parity = 1'b0;
		endcase
	endfunction

	// Merge a 16-bit register with write data under byte enables
	function automatic logic [15:0] uabl_be16(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] be);
		uabl_be16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

endpackage

// [src/uabl_baud.sv]
// Baud tick generator: source select, pin synchronisers and divisor counter
`timescale 1ns/100ps
`default_nettype none
module uabl_baud
	import uabl_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Settings
	input  wire logic [1:0]  clk_sel_i,
	input  wire logic [15:0] divisor_i,
	// Slow sources from pins
	input  wire logic        core_div_i,
	input  wire logic        ext_i,
	// 16x oversampling tick
	output logic             tick16_o
);

	// ********************************************
	// Pin synchronisers
	// ********************************************
	logic [2:0] sync_q [2];
	logic [1:0] lvl_q;
	logic [1:0] rise;
	logic       src_tick;
	logic [15:0] cnt_q;

	// Three stages; a level only counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sync_q[0] <= 3'h0;
			sync_q[1] <= 3'h0;
			lvl_q     <= 2'h0;
		end else begin
			sync_q[0] <= {sync_q[0][1:0], core_div_i};
			sync_q[1] <= {sync_q[1][1:0], ext_i};
			for (int i = 0; i < 2; i++) begin
				if (sync_q[i][1] == sync_q[i][2]) begin
					lvl_q[i] <= sync_q[i][2];
				end
			end
		end
	end

	// Rising edges of the filtered levels
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			rise[i] = (sync_q[i][1] == sync_q[i][2]) && sync_q[i][2] && !lvl_q[i];
		end
		case (clk_sel_i)
			CLK_SEL_EXT:  src_tick = rise[1];
			CLK_SEL_CORE: src_tick = rise[0];
			default:      src_tick = 1'b1;
		endcase
	end

	// ********************************************
	// Divide by divisor plus one
	// ********************************************
	// A divisor lowered below the running count wraps at once, not after 64K ticks
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_q    <= 16'h0000;
			tick16_o <= 1'b0;
		end else begin
			tick16_o <= 1'b0;
			if (src_tick) begin
				if (cnt_q >= divisor_i) begin
					cnt_q    <= 16'h0000;
					tick16_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end

endmodule
`default_nettype wire

// [tb/uabl_peer.sv]
// Remote serial sender driving the receive line with good or broken frames
`timescale 1ns/100ps
`default_nettype none
module uabl_peer #(
	parameter int BIT = 16
) (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [7:0] data_i,
	input  wire logic       stop_ok_i,
	output logic            line_o,
	output logic            busy_o
);
	logic [9:0] sh_q   = 10'h3FF;
	logic       busy_q = 1'b0;
	int         cnt_q  = 0;
	int         bit_q  = 0;
	// Line idles high; start, data LSB first, one stop
	assign line_o = sh_q[0];
	assign busy_o = busy_q;
	// A low stop bit is the only fault a scenario asks for
	always @(posedge clk_i) begin
		if (!busy_q && go_i) begin
			sh_q   <= {stop_ok_i, data_i, 1'b0};
			busy_q <= 1'b1;
			cnt_q  <= 0;
			bit_q  <= 0;
		end else if (busy_q) begin
			cnt_q <= (cnt_q == BIT - 1) ? 0 : cnt_q + 1;
			if (cnt_q == BIT - 1) begin
				sh_q   <= {1'b1, sh_q[9:1]};
				bit_q  <= bit_q + 1;
				busy_q <= (bit_q != 9);
			end
		end
	end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Bench for the serial channel: registers, loopback, error deferral, line timing
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import uabl_pkg::*;
	logic        clk_i    = 1'b0;
	logic        resetn_i = 1'b0;
	logic [31:0] adr      = 32'h0;
	logic        rd       = 1'b0;
	logic        wr       = 1'b0;
	logic [31:0] wd       = 32'h0;
	logic        ext      = 1'b0;
	logic        core     = 1'b0;
	logic        go       = 1'b0;
	logic [7:0]  pd       = 8'h00;
	logic        pok      = 1'b1;
	logic [31:0] rdat;
	logic        wq;
	logic        rxd;
	logic        txd;
	logic        irq;
	logic        pbusy;
	logic [31:0] q;
	int          miscompares = 0;
	int          check_count = 0;
	int          pc = 0;
	int          w;
	// Line format, sent byte, expected byte
	logic [23:0] lb [6] = '{24'h03A5A5, 24'h2AFF7F, 24'h04FF1F, 24'h235A5A, 24'h31FF3F, 24'h3A8101};
	// Control, divisor, line format, expected first pulse width
	logic [39:0] tm [4] = '{40'h0000010320, 40'h0400000380, 40'h0C000103C0, 40'h0000014306};

	always #12.5 clk_i = ~clk_i;
	// Slow baud source pins, periods of 8 and 6 clocks
	always @(posedge clk_i) begin
		pc   <= pc + 1;
		ext  <= (pc % 8) < 4;
		core <= (pc % 6) < 3;
	end

	uabl_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wq), .divided_core_clock_i(core),
		.external_baud_source_i(ext), .rxd_i(rxd), .txd_o(txd), .rx_error_int_o(irq));
	// Peer bit time matches divisor one exactly, so no frame timing error builds up
	uabl_peer #(.BIT(32)) peer (.clk_i(clk_i), .go_i(go), .data_i(pd), .stop_ok_i(pok),
		.line_o(rxd), .busy_o(pbusy));

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Every wait is bounded; running out ends the run as a mismatch
	task automatic guard(inout int c);
		c++;
		if (c > 4000) begin
			miscompares++;
			results;
		end
	endtask
	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w_, input logic [11:0] o, input logic [31:0] d);
		int c = 0;
		@(posedge clk_i);
		adr <= UABL_CH0_BASE | {20'h0, o};
		wr  <= w_;
		rd  <= !w_;
		wd  <= d;
		do begin
			@(posedge clk_i);
			guard(c);
		end while (wq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] o, input logic [31:0] e);
		bus(1'b0, o, 32'h0);
		chk(q, e);
	endtask
	task automatic poll(input int b);
		int c = 0;
		do begin
			bus(1'b0, OFS_STAT, 32'h0);
			guard(c);
		end while (q[b] !== 1'b1);
	endtask
	task automatic send(input logic [7:0] d, input logic ok);
		int c = 0;
		@(posedge clk_i);
		pd  <= d;
		pok <= ok;
		go  <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		do begin
			@(posedge clk_i);
			guard(c);
		end while (pbusy !== 1'b0);
	endtask
	// Width in clocks of the first pulse at level lvl on the serial output
	task automatic meas(input logic lvl, input logic [7:0] e);
		int c = 0;
		while (txd !== lvl) begin
			@(posedge clk_i);
			guard(c);
		end
		w = 0;
		while (txd === lvl) begin
			@(posedge clk_i);
			w++;
			guard(c);
		end
		chk(32'(w), {24'h0, e});
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		rc(OFS_LINE, 32'h0);
		rc(OFS_CTRL, 32'h0);
		rc(OFS_DIV, 32'h0);
		// Reserved bit set, infrared left off so the idle line starts no frame
		bus(1'b1, OFS_LINE, 32'hBF);
		rc(OFS_LINE, 32'h3F);
		rc(12'hFFC, 32'h0);
		// Divisor zero is only legal with the slow external source
		bus(1'b1, OFS_DIV, 32'h1);
		rc(OFS_DIV, 32'h1);
		// Loopback over word lengths, parities and stop counts
		bus(1'b1, OFS_CTRL, 32'h20);
		foreach (lb[i]) begin
			bus(1'b1, OFS_LINE, {24'h0, lb[i][23:16]});
			bus(1'b1, OFS_TXH, {24'h0, lb[i][15:8]});
			poll(ST_RXRDY);
			chk({31'h0, txd}, 32'h1);
			rc(OFS_RXH, {24'h0, lb[i][7:0]});
			rc(OFS_ERR, 32'h0);
		end
		// Error shows only once the faulty character reaches the head
		bus(1'b1, OFS_CTRL, 32'h40);
		bus(1'b1, OFS_LINE, 32'h03);
		send(8'h41, 1'b1);
		send(8'h42, 1'b0);
		// Long enough for the faulty frame to sit behind the clean one
		repeat (8) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		rc(OFS_RXH, 32'h41);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		rc(OFS_ERR, 32'h4);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		rc(OFS_RXH, 32'h42);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		// Bit timing per source and divisor, and infrared pulse width
		foreach (tm[i]) begin
			bus(1'b1, OFS_LINE, {24'h0, tm[i][15:8]});
			bus(1'b1, OFS_CTRL, {16'h0, tm[i][39:24]});
			bus(1'b1, OFS_DIV, {24'h0, tm[i][23:16]});
			bus(1'b1, OFS_TXH, 32'h01);
			meas(tm[i][14], tm[i][7:0]);
			poll(ST_TXE);
		end
		results;
	end
endmodule
`default_nettype wire
